// File: hw/wiper_host.v
`timescale 1ns/1ns
`default_nettype none
`include "wiper_ctl_defines.vh"
// How it works
// [RULE_01] strobe and direction act only while selected
// [RULE_02] each strobe fall moves counter by one
// [RULE_03] direction high steps up, low down
// [RULE_04] five-bit position, thirty-two taps
// [RULE_05] position decodes to single tap
// [RULE_06] counter saturates at both ends
// [RULE_07] deselect with strobe high stores
// [RULE_08] device idles in standby after store
// [RULE_09] deselect with strobe low skips store
// [RULE_10] unstored position kept until changed
// [RULE_11] power-up recalls stored position
// [RULE_12] select held high during power-up
// [RULE_13] direction may change while selected
// [RULE_14] after store keep deselected 10 ms
// [RULE_15] after no-store keep deselected 250 ns
// [RULE_16] device synchronises inputs to its clock
module wiper_host #(
  parameter TW             = 18,
  parameter DESEL_STORE_CYC = `DESEL_STORE_CYC
) (
  input  wire        CLK,
  input  wire        SYS_RST,
  input  wire        CMD_VALID,
  output wire        CMD_READY,
  input  wire        CMD_UP,
  input  wire [4:0]  CMD_STEPS,
  input  wire        CMD_STORE,
  output reg         SEL_N,
  output reg         STROBE_N,
  output reg         DIR_UP,
  output reg  [4:0]  POS_EST,
  output wire        BUSY
);
  // one-hot states
  localparam S_IDLE  = 7'h01;
  localparam S_SETUP = 7'h02;
  localparam S_LOW   = 7'h04;
  localparam S_HIGH  = 7'h08;
  localparam S_TAIL  = 7'h10;
  localparam S_DESEL = 7'h20;
  localparam S_HOLD  = 7'h40;

  // timer loads, cut to the timer width where used
  localparam integer SETUP_CYC   = `SEL_SETUP_CYC;
  localparam integer LOW_CYC     = `STROBE_LOW_CYC;
  localparam integer HIGH_CYC    = `STROBE_HIGH_CYC;
  localparam integer TAIL_CYC    = `STROBE_TO_DESEL_CYC;
  localparam integer NOSTORE_CYC = `DESEL_NOSTORE_CYC;
  localparam integer STORE_CYC   = DESEL_STORE_CYC;

  reg  [6:0]  state_q, state_d;
  reg  [4:0]  steps_q, steps_d;
  reg         store_q, store_d;
  reg         sel_n_d, strobe_n_d, dir_d;
  reg  [4:0]  pos_d;
  reg  [4:0]  pos_step;
  reg         load;
  reg  [TW-1:0] load_val;
  wire        t_done;
  wire        last_keep_low;

  // one down timer paces every pin phase except the one-cycle strobe rise after deselect
  wait_timer #(.W(TW)) u_timer (
    .clk   (CLK),
    .rst   (SYS_RST),
    .load  (load),
    .value (load_val),
    .done  (t_done)
  );

  // ready only when idle and the deselect hold is over
  assign CMD_READY = state_q[0] & t_done;
  assign BUSY      = ~CMD_READY;

  // saturating mirror of one device step
  always @* begin
    pos_step = POS_EST;
    if (DIR_UP & (POS_EST != `POS_MAX)) begin
      pos_step = POS_EST + 5'h01; // RULE_06
    end else if (~DIR_UP & (POS_EST != `POS_MIN)) begin
      pos_step = POS_EST - 5'h01; // RULE_06
    end
  end

  // last fall of a no-store pass keeps the strobe low
  assign last_keep_low = (steps_q == 5'h01) & ~store_q;

  // sequence of one select / step / deselect transaction
  always @* begin
    state_d    = state_q;
    steps_d    = steps_q;
    store_d    = store_q;
    sel_n_d    = SEL_N;
    strobe_n_d = STROBE_N;
    dir_d      = DIR_UP;
    pos_d      = POS_EST;
    load       = 1'b0;
    load_val   = {TW{1'b0}};
    case (state_q)
      // wait for a command; a pass with nothing to do leaves the pins alone
      S_IDLE: begin
        if (CMD_VALID & t_done) begin
          steps_d  = CMD_STEPS;
          store_d  = CMD_STORE;
          load     = 1'b1;
          if ((CMD_STEPS == 5'h00) & ~CMD_STORE) begin
            // any fall while selected would step the wiper
            load_val = NOSTORE_CYC[TW-1:0];
            state_d  = S_HOLD;
          end else begin
            dir_d    = CMD_UP; // RULE_03 RULE_13
            sel_n_d  = 1'b0; // RULE_01
            load_val = SETUP_CYC[TW-1:0];
            state_d  = S_SETUP;
          end
        end
      end
      // select and direction settle before the first fall
      S_SETUP: begin
        if (t_done) begin
          load = 1'b1;
          if (steps_q == 5'h00) begin
            // store with no move: strobe stays high
            load_val = TAIL_CYC[TW-1:0];
            state_d  = S_TAIL; // RULE_07
          end else begin
            strobe_n_d = 1'b0; // RULE_02
            load_val   = LOW_CYC[TW-1:0];
            state_d    = S_LOW;
          end
        end
      end
      // strobe low phase; the device stepped on the fall
      S_LOW: begin
        if (t_done) begin
          steps_d = steps_q - 5'h01;
          pos_d   = pos_step; // RULE_06
          load    = 1'b1;
          if (last_keep_low) begin
            // strobe stays low through deselect: no store
            load_val = TAIL_CYC[TW-1:0];
            state_d  = S_TAIL; // RULE_09
          end else begin
            strobe_n_d = 1'b1;
            load_val   = HIGH_CYC[TW-1:0];
            state_d    = S_HIGH;
          end
        end
      end
      // strobe high phase; next fall or store tail
      S_HIGH: begin
        if (t_done) begin
          load = 1'b1;
          if (steps_q != 5'h00) begin
            strobe_n_d = 1'b0; // RULE_02
            load_val   = LOW_CYC[TW-1:0];
            state_d    = S_LOW;
          end else begin
            // strobe held high into deselect means store
            load_val   = TAIL_CYC[TW-1:0];
            state_d    = S_TAIL; // RULE_07
          end
        end
      end
      // strobe level settled, then select rises
      S_TAIL: begin
        if (t_done) begin
          sel_n_d  = 1'b1; // RULE_07 RULE_09
          load     = 1'b1;
          load_val = store_q ? STORE_CYC[TW-1:0] : NOSTORE_CYC[TW-1:0]; // RULE_14 RULE_15
          state_d  = S_DESEL;
        end
      end
      // strobe back high only once deselected
      S_DESEL: begin
        strobe_n_d = 1'b1;
        state_d    = S_HOLD;
      end
      // deselect hold before the next select
      S_HOLD: begin
        if (t_done) begin
          state_d = S_IDLE; // RULE_08 RULE_10
        end
      end
      // stray code goes back to idle
      default: begin
        state_d = S_IDLE;
      end
    endcase
  end

  // sequencer registers
  always @(posedge CLK) begin
    if (SYS_RST) begin
      state_q  <= S_IDLE;
      steps_q  <= 5'h00;
      store_q  <= 1'b0;
    end else begin
      state_q  <= state_d;
      steps_q  <= steps_d;
      store_q  <= store_d;
    end
  end

  // pin registers; select high from reset
  always @(posedge CLK) begin
    if (SYS_RST) begin
      SEL_N    <= 1'b1; // RULE_12 RULE_11
      STROBE_N <= 1'b1;
      DIR_UP   <= 1'b0;
      POS_EST  <= `POS_MIN;
    end else begin
      SEL_N    <= sel_n_d;
      STROBE_N <= strobe_n_d;
      DIR_UP   <= dir_d;
      POS_EST  <= pos_d;
    end
  end
endmodule // wiper_host
`default_nettype wire

// File: hw/wiper_ctl_defines.vh
`ifndef WIPER_CTL_DEFINES_VH
`define WIPER_CTL_DEFINES_VH
// clock period in ns
`define CLK_PERIOD_NS       40
// select to strobe setup, ns
`define SEL_SETUP_NS        100
// direction setup/hold around strobe, ns
`define DIR_SETUP_NS        100
// strobe low and high periods, ns
`define STROBE_LOW_NS       1000
`define STROBE_HIGH_NS      1000
// strobe inactive to select inactive, ns
`define STROBE_TO_DESEL_NS  1000
// deselect_hold_time without store, ns
`define DESEL_NOSTORE_NS    250
// deselect_hold_time after store, ns (covers nv_write_duration)
`define DESEL_STORE_NS      10000000
// derived cycle counts (minimums round up)
`define CYC_UP(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SEL_SETUP_CYC       `CYC_UP(`SEL_SETUP_NS)
`define DIR_SETUP_CYC       `CYC_UP(`DIR_SETUP_NS)
`define STROBE_LOW_CYC      `CYC_UP(`STROBE_LOW_NS)
`define STROBE_HIGH_CYC     `CYC_UP(`STROBE_HIGH_NS)
`define STROBE_TO_DESEL_CYC `CYC_UP(`STROBE_TO_DESEL_NS)
`define DESEL_NOSTORE_CYC   `CYC_UP(`DESEL_NOSTORE_NS)
`define DESEL_STORE_CYC     `CYC_UP(`DESEL_STORE_NS)
// position counter width and extremes
`define POS_W               5
`define POS_MAX             5'h1f
`define POS_MIN             5'h00
`endif

// File: hw/wait_timer.v
`timescale 1ns/1ns
`default_nettype none
// loadable down counter, done when zero
module wait_timer #(
  parameter W = 20
) (
  input  wire         clk,
  input  wire         rst,
  input  wire         load,
  input  wire [W-1:0] value,
  output wire         done
);
  reg [W-1:0] cnt_q;
  // load or count down to zero
  always @(posedge clk) begin
    if (rst) begin
      cnt_q <= {W{1'b0}};
    end else if (load) begin
      cnt_q <= value;
    end else if (cnt_q != {W{1'b0}}) begin
      cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
    end
  end
  // no path from load to done, so a user may load on done without a loop
  assign done = (cnt_q == {W{1'b0}});
endmodule // wait_timer
`default_nettype wire

// File: test/wiper_host_monitor.sv
`timescale 1ns/1ns
`default_nettype none
// host pin timing checks
module wiper_host_monitor #(parameter DESEL_STORE_CYC = 250000) (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic SEL_N,
  input wire logic STROBE_N,
  input wire logic DIR_UP,
  input wire logic BUSY
);
  logic [19:0] gap_q;
  logic        st_q;
  // deselected time, kind of last deselect
  always @(posedge CLK) begin
    gap_q <= SYS_RST ? 20'h80000 : (SEL_N ? gap_q + 20'h1 : 20'h0);
    st_q  <= SYS_RST ? 1'b0 : ($rose(SEL_N) ? STROBE_N : st_q);
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  a_reset_idle: assert property ($fell(SYS_RST) |-> SEL_N && STROBE_N)
    else $error("pins active after reset");
  a_desel_gap: assert property (
    $fell(SEL_N) |-> gap_q >= (st_q ? DESEL_STORE_CYC : 7)) else $error("deselect short");
  a_sel_setup: assert property ($fell(STROBE_N) |-> !SEL_N && !$past(SEL_N, 3))
    else $error("strobe without select");
  a_dir_setup: assert property ($fell(STROBE_N) |-> DIR_UP == $past(DIR_UP, 3))
    else $error("direction moved");
  a_busy_sel: assert property (!SEL_N |-> BUSY)
    else $error("ready while selected");
  // select rise ends a pass; strobe level there picks store or not
  sequence s_desel;
    $rose(SEL_N);
  endsequence
  a_strobe_hold: assert property (s_desel |-> STROBE_N == $past(STROBE_N, 8))
    else $error("strobe moved before deselect");
  a_strobe_rest: assert property (s_desel |=> STROBE_N)
    else $error("strobe low after deselect");
endmodule // wiper_host_monitor
`default_nettype wire

// File: test/wiper_dev.sv
`timescale 1ns/1ns
`default_nettype none
// wiper device, stepped by strobe fall
module wiper_dev #(parameter NV_INIT = 5'h0a) (
  input  wire logic       sel_n,
  input  wire logic       step_n,
  input  wire logic       dir_up,
  output var  logic [4:0] pos,
  output var  logic [4:0] nv,
  output var  int         n_store
);
  logic armed = 1'b0;
  // recall at power-up
  initial begin
    nv = NV_INIT;
    pos = NV_INIT;
    n_store = 0;
  end
  // saturating step while selected
  always @(negedge step_n) begin
    if (!sel_n && dir_up) pos <= pos + 5'(pos != 5'h1f);
    if (!sel_n && !dir_up) pos <= pos - 5'(pos != 5'h00);
  end
  // store only on select rise with strobe high
  always @(negedge sel_n) armed <= 1'b1;
  always @(posedge sel_n) begin
    if (armed && step_n) begin
      nv <= pos;
      n_store <= n_store + 1;
    end
  end
endmodule // wiper_dev
`default_nettype wire

// File: test/wiper_host_tb.sv
`timescale 1ns/1ns
`default_nettype none
module wiper_host_tb;
  logic       clk = 0, rst = 1, vld = 0, up = 0, sto = 0;
  logic [4:0] stp = 0, est, pos, nv, e_pos = 5'h0a, e_est = 0;
  wire        sel_n, step_n, dir_up, rdy, busy;
  int         n_fail = 0, total_checks = 0, ns, e_ns = 0, k;
  // 25 MHz clock
  always #20 clk = ~clk;
  wiper_host #(.DESEL_STORE_CYC(50)) i_wiper_host (.CLK(clk), .SYS_RST(rst), .CMD_VALID(vld),
    .CMD_READY(rdy), .CMD_UP(up), .CMD_STEPS(stp), .CMD_STORE(sto), .SEL_N(sel_n),
    .STROBE_N(step_n), .DIR_UP(dir_up), .POS_EST(est), .BUSY(busy));
  wiper_dev i_dev (.sel_n(sel_n), .step_n(step_n), .dir_up(dir_up), .pos(pos), .nv(nv),
    .n_store(ns));
  // expected saturating walk
  function automatic logic [4:0] walk(input logic [4:0] p, input logic u, input logic [4:0] n);
    for (int i = 0; i < n; i++) p = u ? p + 5'(p != 5'h1f) : p - 5'(p != 5'h00);
    return p;
  endfunction
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s exp %0h got %0h", s, e, g);
    end
  endtask
  task automatic results;
    $display("checks %0d fails %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // one command, then compare device state
  task automatic cmd(input logic u, input logic [4:0] n, input logic s);
    vld = 1;
    up = u;
    stp = n;
    sto = s;
    k = 0;
    do @(negedge clk); while (busy !== 1'b1 && ++k < 99);
    vld = 0;
    do @(negedge clk); while (rdy !== 1'b1 && ++k < 3000);
    e_pos = walk(e_pos, u, n);
    e_est = walk(e_est, u, n);
    e_ns += s;
    chk("wiper", e_pos, pos);
    chk("estimate", e_est, est);
    chk("stores", e_ns, ns);
    if (s) chk("stored", e_pos, nv);
    if (k >= 3000) chk("ready", 1, 0);
  endtask
  // reset, corners, random traffic
  initial begin
    void'($urandom(58152));
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst = 0;
    chk("recall", 5'h0a, pos);
    cmd(1, 5'h1f, 0);
    cmd(0, 5'h00, 1);
    cmd(0, 5'h1f, 0);
    cmd(1, 5'h03, 1);
    repeat (12) cmd(1'($urandom), 5'($urandom), 1'($urandom));
    results;
  end
  // hang guard
  initial begin
    #2000000;
    n_fail++;
    results;
  end
endmodule // wiper_host_tb
bind wiper_host wiper_host_monitor #(.DESEL_STORE_CYC(DESEL_STORE_CYC)) i_mon (.CLK(CLK),
  .SYS_RST(SYS_RST), .SEL_N(SEL_N), .STROBE_N(STROBE_N), .DIR_UP(DIR_UP), .BUSY(BUSY));
`default_nettype wire
